// >>> logic/usrc_top.sv
`timescale 1ns/100ps
module usrc_top #(
    parameter int unsigned DATA_W  = usrc_pkg::DATA_W,
    parameter int unsigned MODEM_W = usrc_pkg::MODEM_W
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               srst,

    // Host control bits
    input  wire logic [7:0]         enhanced_feature_reg,
    input  wire logic [7:0]         interrupt_enable_reg,
    input  wire logic [7:0]         alt_function_ctrl_one,
    input  wire logic [7:0]         extended_function_ctrl_two,
    input  wire logic [7:0]         modem_control_reg,
    input  wire logic [DATA_W-1:0]  second_stop_char_reg,
    input  wire logic               hw_flow_en,
    input  wire logic               flow_rts_n,

    // Host receiver enable write
    input  wire logic               rx_en_wr,
    input  wire logic               rx_en_wdata,

    // Power-down pin
    input  wire logic               power_down_pin,

    // Line and modem pins
    input  wire logic               rx_pin,
    input  wire logic [MODEM_W-1:0] modem_in,
    output logic                    rts_n_pin,

    // UART core status
    input  wire logic               baud_tick16,
    input  wire logic               tx_fifo_wr,
    input  wire logic               tx_fifo_empty,
    input  wire logic               tsr_empty,
    input  wire logic               tx_last_bit_done,
    input  wire logic               int_pending,
    input  wire logic               rx_fifo_empty,

    // Received character from the deserialiser
    input  wire logic               rxc_valid,
    output logic                    rxc_ready,
    input  wire logic [DATA_W-1:0]  rxc_data,
    input  wire logic               rxc_parity,
    input  wire logic               rxc_perr,

    // Character towards the receive FIFO
    output logic                    fifo_valid,
    input  wire logic               fifo_ready,
    output logic [DATA_W-1:0]       fifo_data,
    output logic                    fifo_perr,

    // Status and clock control
    output logic                    line_int_req,
    output logic                    rx_on,
    output logic                    sleeping,
    output logic                    low_power,
    output logic                    host_isolate,
    output logic                    uart_clk_en,
    output logic                    baud_clk_en
);

    function automatic logic is_address(input logic nine, input logic parity);
        return nine && parity;
    endfunction

    function automatic logic addr_hit(input logic [DATA_W-1:0] a,
                                      input logic [DATA_W-1:0] b);
        return a == b;
    endfunction

    // ---- Control bit decode
    wire enh_en      = enhanced_feature_reg[usrc_pkg::EFR_ENH_BIT];
    wire special_en  = enhanced_feature_reg[usrc_pkg::EFR_SPECIAL_BIT];
    wire sleep_en    = interrupt_enable_reg[usrc_pkg::IER_SLEEP_BIT];
    wire lsi_en      = interrupt_enable_reg[usrc_pkg::IER_LSI_BIT];
    wire rx_ignore   = alt_function_ctrl_one[usrc_pkg::ALT_FUNCTION_CTRL_ONE_RXLOW_BIT];
    wire mcr_rts     = modem_control_reg[usrc_pkg::MCR_RTS_BIT];
    wire nine_en     = extended_function_ctrl_two[usrc_pkg::EXTENDED_FUNCTION_CTRL_TWO_NINE_BIT];
    wire auto_rts    = extended_function_ctrl_two[usrc_pkg::EXTENDED_FUNCTION_CTRL_TWO_ARTS_BIT];
    wire rts_inv     = extended_function_ctrl_two[usrc_pkg::EXTENDED_FUNCTION_CTRL_TWO_INV_BIT];

    // ---- State
    usrc_pkg::usrc_state_t              state_reg;
    usrc_pkg::usrc_state_t              state_next;
    logic [usrc_pkg::IDLE_CNT_W-1:0]    idle_cnt_reg;
    logic                               rx_prev_reg;
    logic [MODEM_W-1:0]                 modem_prev_reg;
    logic                               tx_pend_reg;
    logic                               rts_n_reg;
    logic                               rx_on_reg;
    logic                               lsi_reg;
    logic                               lp_reg;

    // ---- Wake and entry terms, all on the free-running mclk
    wire start_edge  = rx_prev_reg && !rx_pin;
    wire modem_chg   = (modem_in != modem_prev_reg);
    wire wake_evt    = start_edge || tx_fifo_wr || modem_chg;
    wire sleep_allow = enh_en && sleep_en;
    wire idle_done   = (idle_cnt_reg == usrc_pkg::IDLE_CNT_W'(usrc_pkg::IDLE_TICKS));
    wire rx_quiet    = rx_ignore || (idle_done && rx_pin);
    wire core_quiet  = !modem_chg && tx_fifo_empty && tsr_empty
                     && !int_pending && rx_fifo_empty;
    wire enter_ok    = sleep_allow && rx_quiet && core_quiet && !wake_evt;

    // Idle counter runs on baud ticks and restarts whenever RX is low
    wire [usrc_pkg::IDLE_CNT_W-1:0] idle_cnt_next =
        !rx_pin   ? '0 :
        idle_done ? idle_cnt_reg :
        baud_tick16 ? idle_cnt_reg + 1'h1 : idle_cnt_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            usrc_pkg::ST_RUN: begin
                if (enter_ok) begin
                    state_next = usrc_pkg::ST_SLEEP;
                end
            end
            usrc_pkg::ST_SLEEP: begin
                if (wake_evt || !sleep_allow) begin
                    state_next = usrc_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg      <= usrc_pkg::ST_RUN;
            idle_cnt_reg   <= '0;
            rx_prev_reg    <= 1'h1;
            modem_prev_reg <= '0;
            lp_reg         <= 1'h0;
        end else begin
            state_reg      <= state_next;
            idle_cnt_reg   <= idle_cnt_next;
            rx_prev_reg    <= rx_pin;
            modem_prev_reg <= modem_in;
            lp_reg         <= power_down_pin;
        end
    end

    // Low-power pin stops both clock enables whatever the sleep state, so it is not part of the sleep machine
    assign sleeping     = (state_reg == usrc_pkg::ST_SLEEP);
    assign low_power    = lp_reg;
    assign host_isolate = lp_reg;

    usrc_clk_gate u_gate (
        .mclk        (mclk),
        .srst        (srst),
        .stop_sleep  (sleeping),
        .stop_power_down_pin (power_down_pin),
        .uart_clk_en (uart_clk_en),
        .baud_clk_en (baud_clk_en)
    );

    // ---- RTS control
    // The pending flag spans the whole burst; a write in the same cycle as the
    // final-bit pulse keeps it pending so the driver is not turned round early.
    wire tx_pend_next = tx_fifo_wr ? 1'h1 :
                        (tx_last_bit_done && tx_fifo_empty) ? 1'h0 : tx_pend_reg;

    wire auto_rts_n   = rts_inv ? tx_pend_reg : !tx_pend_reg;
    wire manual_rts_n = hw_flow_en ? flow_rts_n : !mcr_rts;
    wire rts_n_next   = auto_rts ? auto_rts_n : manual_rts_n;

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_pend_reg <= 1'h0;
            rts_n_reg   <= usrc_pkg::RTS_N_RESET;
        end else begin
            tx_pend_reg <= tx_pend_next;
            rts_n_reg   <= rts_n_next;
        end
    end

    assign rts_n_pin = rts_n_reg;

    // ---- Multidrop receive filter
    usrc_stream_if #(.W(DATA_W)) rx_s ();

    wire take      = rxc_valid && rx_s.ready;
    wire is_addr   = is_address(nine_en, rxc_parity);
    wire hit       = addr_hit(rxc_data, second_stop_char_reg);
    wire auto_mode = nine_en && special_en;
    wire norm_mode = nine_en && !special_en;

    // Store decision for each mode
    wire keep_plain = !nine_en && rx_on_reg;
    wire keep_norm  = norm_mode && (is_addr || rx_on_reg);
    wire keep_auto  = auto_mode && (is_addr ? hit : rx_on_reg);
    wire keep       = keep_plain || keep_norm || keep_auto;

    // In nine-bit mode the parity bit stands in the parity-error position
    wire perr_out   = nine_en ? rxc_parity : rxc_perr;

    wire auto_set   = take && auto_mode && is_addr && hit;
    wire auto_clr   = take && auto_mode && is_addr && !hit;
    wire host_clr   = rx_en_wr && !rx_en_wdata;
    wire host_set   = rx_en_wr && rx_en_wdata;

    // Hardware enable wins over a host disable in the same cycle
    wire rx_on_next = (auto_set || host_set) ? 1'h1 :
                      (auto_clr || host_clr) ? 1'h0 : rx_on_reg;

    wire lsi_next   = take && keep && is_addr && lsi_en;

    assign rx_s.valid = rxc_valid && keep;
    assign rx_s.data  = rxc_data;
    assign rx_s.perr  = perr_out;
    // Dropped characters are consumed only when the buffer could take them,
    // keeping one acceptance condition for every character.
    assign rxc_ready  = rx_s.ready;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_on_reg <= usrc_pkg::RX_ON_RESET;
            lsi_reg   <= 1'h0;
        end else begin
            rx_on_reg <= rx_on_next;
            lsi_reg   <= lsi_next;
        end
    end

    assign rx_on        = rx_on_reg;
    assign line_int_req = lsi_reg;

    usrc_rx_buf #(.W(DATA_W)) u_buf (
        .mclk      (mclk),
        .srst      (srst),
        .in_s      (rx_s),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data),
        .out_perr  (fifo_perr)
    );

endmodule

// >>> logic/usrc_pkg.sv
package usrc_pkg;

    // Character framing used to measure receive-line idle time
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned MODEM_W     = 4;
    localparam int unsigned OVERSAMPLE  = 16;
    localparam int unsigned CHAR_BITS   = 10;
    localparam int unsigned IDLE_CHARS  = 4;
    localparam int unsigned IDLE_TICKS  = OVERSAMPLE * CHAR_BITS * IDLE_CHARS;
    localparam int unsigned IDLE_CNT_W  = $clog2(IDLE_TICKS + 1);

    // Bit positions of the control bits as they sit in their host registers
    localparam int unsigned EFR_ENH_BIT      = 4;
    localparam int unsigned EFR_SPECIAL_BIT  = 5;
    localparam int unsigned IER_LSI_BIT      = 2;
    localparam int unsigned IER_SLEEP_BIT    = 4;
    localparam int unsigned MCR_RTS_BIT      = 1;
    localparam int unsigned ALT_FUNCTION_CTRL_ONE_RXLOW_BIT  = 4;
    localparam int unsigned EXTENDED_FUNCTION_CTRL_TWO_NINE_BIT   = 0;
    localparam int unsigned EXTENDED_FUNCTION_CTRL_TWO_ARTS_BIT   = 4;
    localparam int unsigned EXTENDED_FUNCTION_CTRL_TWO_INV_BIT    = 5;
    localparam int unsigned LSR_PERR_BIT     = 2;

    // Reset values of the state this block owns
    localparam logic        RTS_N_RESET  = 1'h1;
    localparam logic        RX_ON_RESET  = 1'h0;
    localparam logic [7:0]  DATA_RESET   = 8'h00;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_SLEEP
    } usrc_state_t;

endpackage

// >>> logic/usrc_stream_if.sv
`timescale 1ns/100ps
interface usrc_stream_if #(
    parameter int unsigned W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    logic         perr;

    modport src (
        output valid,
        output data,
        output perr,
        input  ready
    );

    modport snk (
        input  valid,
        input  data,
        input  perr,
        output ready
    );
endinterface

// >>> logic/usrc_clk_gate.sv
`timescale 1ns/100ps
module usrc_clk_gate (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Stop requests
    input  wire logic stop_sleep,
    input  wire logic stop_power_down_pin,
    // Enables for the gated domains
    output logic      uart_clk_en,
    output logic      baud_clk_en
);
    logic uart_en_reg;
    logic baud_en_reg;
    logic run;

    assign run = !(stop_sleep || stop_power_down_pin);

    // Enables only change on an mclk edge, so the downstream gate never glitches
    always_ff @(posedge mclk) begin
        if (srst) begin
            uart_en_reg <= 1'h1;
            baud_en_reg <= 1'h1;
        end else begin
            uart_en_reg <= run;
            baud_en_reg <= run;
        end
    end

    assign uart_clk_en = uart_en_reg;
    assign baud_clk_en = baud_en_reg;
endmodule

// >>> logic/usrc_rx_buf.sv
`timescale 1ns/100ps
module usrc_rx_buf #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         srst,
    // Filling side
    usrc_stream_if.snk        in_s,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic              out_perr
);
    logic [W:0] mem [2];
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic [1:0] cnt_reg;
    logic       push;
    logic       pop;

    assign in_s.ready = (cnt_reg != 2'h2);
    assign out_valid  = (cnt_reg != 2'h0);
    assign push       = in_s.valid && in_s.ready;
    assign pop        = out_valid && out_ready;
    assign out_data   = mem[rd_ptr_reg][W-1:0];
    assign out_perr   = mem[rd_ptr_reg][W];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= {in_s.perr, in_s.data};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ptr_reg <= 1'h0;
            rd_ptr_reg <= 1'h0;
            cnt_reg    <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            cnt_reg    <= cnt_reg + {1'h0, push} - {1'h0, pop};
        end
    end
endmodule

// >>> verification/usrc_top_props.sv
`timescale 1ns/100ps
module usrc_top_props #(
    parameter int unsigned DATA_W  = usrc_pkg::DATA_W,
    parameter int unsigned MODEM_W = usrc_pkg::MODEM_W
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               srst,
    // Host control
    input wire logic [7:0]         enhanced_feature_reg,
    input wire logic [7:0]         interrupt_enable_reg,
    input wire logic [7:0]         alt_function_ctrl_one,
    input wire logic [7:0]         extended_function_ctrl_two,
    input wire logic [7:0]         modem_control_reg,
    input wire logic               hw_flow_en,
    input wire logic               power_down_pin,
    // Line and core status
    input wire logic               rx_pin,
    input wire logic [MODEM_W-1:0] modem_in,
    input wire logic               tx_fifo_wr,
    input wire logic               tx_fifo_empty,
    input wire logic               tsr_empty,
    input wire logic               tx_last_bit_done,
    input wire logic               int_pending,
    input wire logic               rx_fifo_empty,
    input wire logic               rxc_valid,
    input wire logic               rxc_ready,
    input wire logic               rxc_parity,
    input wire logic               fifo_valid,
    input wire logic               fifo_ready,
    input wire logic [DATA_W-1:0]  fifo_data,
    // Outputs
    input wire logic               rts_n_pin,
    input wire logic               line_int_req,
    input wire logic               sleeping,
    input wire logic               low_power,
    input wire logic               uart_clk_en,
    input wire logic               baud_clk_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic sl_ok = enhanced_feature_reg[4] && interrupt_enable_reg[4];
    wire logic arts  = extended_function_ctrl_two[4];

    AST_LP: assert property (1'h1 |=> low_power == $past(power_down_pin))
        else $error("low power does not follow pin");
    AST_LP_CLK: assert property (power_down_pin |=> !uart_clk_en && !baud_clk_en)
        else $error("clocks run in low power");
    AST_SL_IN: assert property ($rose(sleeping) |->
        $past(sl_ok && tx_fifo_empty && tsr_empty && rx_fifo_empty && !int_pending))
        else $error("sleep entered without conditions");
    AST_SL_RX: assert property ($rose(sleeping) |-> $past(alt_function_ctrl_one[4] || rx_pin))
        else $error("sleep entered with line low");
    AST_SL_CLK: assert property (sleeping |=> !uart_clk_en && !baud_clk_en)
        else $error("clocks run while asleep");
    AST_WAKE: assert property (sleeping &&
        (tx_fifo_wr || $fell(rx_pin) || modem_in != $past(modem_in)) |=> !sleeping)
        else $error("no wake on event");
    AST_SL_OFF: assert property (sleeping && !sl_ok |=> !sleeping)
        else $error("asleep with sleep disabled");
    AST_RTS_MAN: assert property (!arts && !hw_flow_en |=> rts_n_pin == !$past(modem_control_reg[1]))
        else $error("rts does not follow modem control");
    AST_RTS_ON: assert property (arts && tx_fifo_wr ##1 arts && !tx_last_bit_done |=>
        rts_n_pin == $past(extended_function_ctrl_two[5]))
        else $error("rts not asserted on write");
    AST_RTS_OFF: assert property (arts && tx_last_bit_done && tx_fifo_empty && !tx_fifo_wr
        ##1 arts && !tx_fifo_wr |=> rts_n_pin != $past(extended_function_ctrl_two[5]))
        else $error("rts not released after last bit");
    AST_INT: assert property (line_int_req |->
        $past(rxc_valid && rxc_ready && extended_function_ctrl_two[0] && rxc_parity && interrupt_enable_reg[2]))
        else $error("line interrupt without address");
    AST_HOLD: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
        else $error("buffer output changed while stalled");
endmodule
bind usrc_top usrc_top_props #(.DATA_W(DATA_W), .MODEM_W(MODEM_W)) u_props (.*);

// >>> verification/usrc_line_model.sv
`timescale 1ns/100ps
module usrc_line_model (
    // Clock
    input  wire logic       mclk,
    // Characters from the line
    output logic            rxc_valid,
    input  wire logic       rxc_ready,
    output logic [7:0]      rxc_data,
    output logic            rxc_parity,
    output logic            rxc_perr,
    // Handshake never completed
    output logic            stuck
);
    initial begin
        {rxc_valid, rxc_parity, rxc_perr, stuck} = 4'h0;
        rxc_data = 8'h00;
    end

    task automatic send(input logic [7:0] d, input logic p);
        int n;
        @(negedge mclk);
        rxc_valid  = 1'h1;
        rxc_data   = d;
        rxc_parity = p;
        // Opposite of the ninth bit, so a wrong pick of flag shows up
        rxc_perr   = !p;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rxc_ready !== 1'h1 && n < 100);
        if (rxc_ready !== 1'h1)
            stuck = 1'h1;
        @(negedge mclk);
        rxc_valid  = 1'h0;
        rxc_data   = ~d;
        rxc_parity = !p;
    endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
    logic       mclk, srst, hw_flow_en, flow_rts_n, rx_en_wr, rx_en_wdata, power_down_pin, rx_pin, stuck;
    logic       baud_tick16, tx_fifo_wr, tx_fifo_empty, tsr_empty, tx_last_bit_done, int_pending;
    logic       rx_fifo_empty, rxc_valid, rxc_ready, rxc_parity, rxc_perr, fifo_valid, fifo_ready, fifo_perr;
    logic       line_int_req, rx_on, sleeping, low_power, host_isolate, uart_clk_en, baud_clk_en, rts_n_pin;
    logic [7:0] enhanced_feature_reg, interrupt_enable_reg, alt_function_ctrl_one, extended_function_ctrl_two;
    logic [7:0] modem_control_reg, second_stop_char_reg, rxc_data, fifo_data;
    logic [3:0] modem_in;
    logic [8:0] exp_q[$];
    int         miscompares, compares, int_cnt;

    usrc_top dut (.*);
    usrc_line_model line (.*);

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(negedge mclk) baud_tick16 <= ~baud_tick16;

    // Drained words are matched in order; an unexpected word is a failure
    always @(posedge mclk) begin
        if (line_int_req === 1'h1)
            int_cnt++;
        if (fifo_valid === 1'h1 && fifo_ready === 1'h1) begin
            check(exp_q.size() != 0, 1'h1);
            if (exp_q.size() != 0)
                check({fifo_perr, fifo_data}, exp_q.pop_front());
        end
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // k: 2 transmit write, 1 last bit done, 0 receiver enable write
    task automatic strobe(input int k, input logic v);
        @(negedge mclk);
        {tx_fifo_wr, tx_last_bit_done, rx_en_wr} = 3'h1 << k;
        rx_en_wdata = v;
        @(negedge mclk);
        {tx_fifo_wr, tx_last_bit_done, rx_en_wr} = 3'h0;
    endtask

    task automatic wait_sl(input logic v, input int n);
        while (sleeping !== v && n > 0) begin
            @(negedge mclk);
            n--;
        end
        check(sleeping, v);
        if (sleeping !== v)
            finish_test();
    endtask

    task automatic t_lowpower();
        power_down_pin = 1'h1;
        cyc(2);
        check({low_power, host_isolate, uart_clk_en, baud_clk_en}, 4'hC);
        power_down_pin = 1'h0;
        cyc(2);
        check({low_power, host_isolate, uart_clk_en, baud_clk_en}, 4'h3);
    endtask

    task automatic t_sleep();
        {interrupt_enable_reg, alt_function_ctrl_one} = 16'h1010;
        cyc(50);
        check(sleeping, 1'h0);
        enhanced_feature_reg = 8'h10;
        int_pending = 1'h1;
        cyc(50);
        check(sleeping, 1'h0);
        int_pending = 1'h0;
        wait_sl(1'h1, 10);
        cyc(2);
        check({uart_clk_en, baud_clk_en}, 2'h0);
        strobe(2, 1'h0);
        wait_sl(1'h0, 4);
        wait_sl(1'h1, 10);
        modem_in = 4'h1;
        wait_sl(1'h0, 4);
        wait_sl(1'h1, 10);
        alt_function_ctrl_one = 8'h00;
        cyc(2);
        rx_pin = 1'h0;
        wait_sl(1'h0, 4);
        cyc(20);
        rx_pin = 1'h1;
        cyc(200);
        check(sleeping, 1'h0);
        wait_sl(1'h1, 3000);
        // Divisor writes are only safe once sleep is disabled
        interrupt_enable_reg = 8'h00;
        wait_sl(1'h0, 4);
    endtask

    task automatic t_rts();
        // The wake write of the sleep scenario left a burst pending; end it first
        strobe(1, 1'h0);
        for (int inv = 0; inv < 2; inv++) begin
            extended_function_ctrl_two = 8'h00;
            modem_control_reg = 8'h02;
            cyc(3);
            check(rts_n_pin, 1'h0);
            {hw_flow_en, flow_rts_n} = 2'h3;
            cyc(3);
            check(rts_n_pin, 1'h1);
            hw_flow_en = 1'h0;
            extended_function_ctrl_two = inv ? 8'h30 : 8'h10;
            cyc(3);
            check(rts_n_pin, !inv[0]);
            tx_fifo_empty = 1'h0;
            strobe(2, 1'h0);
            cyc(2);
            check(rts_n_pin, inv[0]);
            tx_fifo_empty = 1'h1;
            strobe(1, 1'h0);
            cyc(2);
            check(rts_n_pin, !inv[0]);
        end
        {extended_function_ctrl_two, modem_control_reg} = 16'h0000;
    endtask

    task automatic t_rx_normal();
        hw_flow_en = 1'h0;
        {extended_function_ctrl_two, interrupt_enable_reg} = 16'h0104;
        line.send(8'h11, 1'h0);
        exp_q.push_back(9'h15A);
        line.send(8'h5A, 1'h1);
        cyc(3);
        check(int_cnt[8:0], 9'h001);
        strobe(0, 1'h1);
        fifo_ready = 1'h0;
        exp_q = {exp_q, 9'h022, 9'h133, 9'h044};
        fork
            begin
                line.send(8'h22, 1'h0);
                line.send(8'h33, 1'h1);
                line.send(8'h44, 1'h0);
            end
            begin
                cyc(30);
                check(rxc_ready, 1'h0);
                fifo_ready = 1'h1;
            end
        join
        cyc(4);
        check(int_cnt[8:0], 9'h002);
        check(exp_q.size() == 0, 1'h1);
    endtask

    task automatic t_rx_auto();
        enhanced_feature_reg = 8'h30;
        second_stop_char_reg = 8'h5A;
        strobe(0, 1'h0);
        line.send(8'h66, 1'h0);
        line.send(8'h33, 1'h1);
        exp_q.push_back(9'h15A);
        line.send(8'h5A, 1'h1);
        cyc(2);
        check(rx_on, 1'h1);
        exp_q.push_back(9'h077);
        line.send(8'h77, 1'h0);
        line.send(8'h33, 1'h1);
        cyc(2);
        check(rx_on, 1'h0);
        line.send(8'h88, 1'h0);
        cyc(4);
        check(exp_q.size() == 0, 1'h1);
        check(int_cnt[8:0], 9'h003);
        // Without nine-bit mode only the receiver enable decides and the error flag passes
        extended_function_ctrl_two = 8'h00;
        line.send(8'hA5, 1'h1);
        strobe(0, 1'h1);
        exp_q.push_back(9'h099);
        line.send(8'h99, 1'h1);
        cyc(4);
        check(exp_q.size() == 0, 1'h1);
        check(int_cnt[8:0], 9'h003);
    endtask

    initial begin
        {srst, power_down_pin, hw_flow_en, flow_rts_n, rx_en_wr, rx_en_wdata} = 6'h20;
        {tx_fifo_wr, tx_last_bit_done, int_pending, baud_tick16} = 4'h0;
        {tx_fifo_empty, tsr_empty, rx_fifo_empty, rx_pin, fifo_ready} = 5'h1F;
        {enhanced_feature_reg, interrupt_enable_reg, alt_function_ctrl_one, extended_function_ctrl_two} = 32'h0;
        {modem_control_reg, second_stop_char_reg, modem_in} = 20'h0;
        {miscompares, compares, int_cnt} = '0;
        cyc(4);
        srst = 1'h0;
        cyc(1);
        check({rts_n_pin, rx_on, sleeping, low_power, uart_clk_en, baud_clk_en, fifo_valid, rxc_ready, line_int_req}, 9'h11A);
        t_lowpower();
        t_sleep();
        t_rts();
        t_rx_normal();
        t_rx_auto();
        check(stuck, 1'h0);
        finish_test();
    end
endmodule
